/* File: hdl/io_switch_matrix_pwm.sv */
// io switch matrix routing 25 sources to 18 destinations, with pwm definitions
// Operation
// - any source 0..24 may be routed to any destination 0..17
// - two routed lines feed the logic unit; its result returns as a source
// - pulse-loop 0,1 outputs are sources 6,7; units 2,3 are 20,21
// - sequencer first interval pulse is source 12, running flag source 15
// - sequencer pwm outputs a..d are sources 8, 9, 13, 14
// - sequencer second interval pulse, the pwm mask, is source 18
// - debounce is source 16, prescaler 17, logic unit 19
// - destinations 13..16 trigger pulse-loop units 0..3
// - destination 7 triggers the sequencer
// - destination 8 feeds the debounce filter
// - destination 9 feeds the prescaler
// - destinations 10 and 11 are logic unit operands a and b
// - destinations 0..3 drive open-drain outputs; unpopulated ones stay released
// - each line has a selectable inverter
// - each line has a force-high option
// - force-high plus inverter drives the line low
// - routing can be saved, reloaded, and reset to factory default
// - destination 6 drives the internal acquisition trigger
// - pwm period is period register times 15 ns, per interval
// - four channels hold per-interval duty percent setting high time
`timescale 1ns/1ps
module io_switch_matrix_pwm
    import iosw_pkg::*;
#(
    parameter int unsigned NUM_OD        = 4,
    parameter int unsigned NUM_INTERVALS = 16,
    parameter int unsigned PERIOD_W      = 16
)(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // external pins (asynchronous)
    input  wire logic [3:0]                    io_in_i,
    input  wire logic                          io_rxd_i,
    input  wire logic                          mft_rxd_i,
    // on-chip sources
    input  wire logic                          txd_uart1_i,
    input  wire logic                          txd_uart2_i,
    input  wire logic [3:0]                    strobe_i,
    input  wire logic                          expose_i,
    input  wire logic                          readout_i,
    input  wire logic                          seq_pulse_a_i,
    input  wire logic                          seq_pulse_b_i,
    input  wire logic                          seq_active_i,
    input  wire logic                          debounce_out_i,
    input  wire logic                          prescale_out_i,
    input  wire logic                          logic_result_i,
    input  wire logic                          trigger_feedback_i,
    // routing configuration
    input  wire logic                          route_we_i,
    input  wire logic [SEL_W-1:0]              route_dst_i,
    input  wire iosw_route_t                   route_i,
    input  wire logic                          route_default_i,
    input  wire logic                          route_save_i,
    input  wire logic                          route_load_i,
    input  wire iosw_table_t                   nv_image_i,
    // pwm configuration
    input  wire logic                          pwm_we_i,
    input  wire logic [$clog2(NUM_INTERVALS)-1:0] interval_index_i,
    input  wire logic [PERIOD_W-1:0]           pwm_period_ticks_i,
    input  wire iosw_duty_t                    pwm_duty_percent_i,
    input  wire logic [$clog2(NUM_INTERVALS)-1:0] seq_interval_i,
    // routing state and storage
    output iosw_table_t                        route_table_o,
    output iosw_table_t                        nv_image_o,
    output logic                               nv_save_o,
    // destinations
    output logic [3:0]                         io_out_o,
    output logic [3:0]                         io_out_oe_o,
    output logic                               io_txd_o,
    output logic                               rxd_uart1_o,
    output logic                               rxd_uart2_o,
    output logic                               acq_trigger_o,
    output logic                               seq_start_input_o,
    output logic                               debounce_in_o,
    output logic                               prescale_in_o,
    output logic                               logic_a_o,
    output logic                               logic_b_o,
    output logic                               mft_txd_o,
    output logic [3:0]                         pulse_trig_o,
    // pwm outputs
    output logic                               seq_pwm_a,
    output logic                               seq_pwm_b,
    output logic                               seq_pwm_c,
    output logic                               seq_pwm_d
);
    localparam int unsigned IW = $clog2(NUM_INTERVALS);
    localparam int unsigned NSYNC = 6;

    if (NUM_OD < 1 || NUM_OD > 4)
        $error("NUM_OD must be 1..4");
    if (NUM_INTERVALS < 2 || (1 << IW) != NUM_INTERVALS)
        $error("NUM_INTERVALS must be a power of two");
    if (PERIOD_W < 2 || PERIOD_W > 24)
        $error("PERIOD_W must be 2..24");

    typedef struct packed {
        logic [NSYNC-1:0]                          sync1;
        logic [NSYNC-1:0]                          sync2;
        iosw_table_t                               table_r;
        iosw_table_t                               image;
        logic                                      save;
        logic [NDST-1:0]                           dst;
        logic [3:0]                                od_oe;
        logic [ACC_W-1:0]                          acc;
        logic                                      tick;
        logic [NUM_INTERVALS-1:0][PERIOD_W-1:0]    period;
        logic [NUM_INTERVALS-1:0][NPWM-1:0][DUTY_W-1:0] duty;
    } iosw_state_t;

    iosw_state_t st_q;
    iosw_state_t st_d;
    logic [NPWM-1:0] pwm;

    // pwm channels use the period and duty of the running interval
    for (genvar c = 0; c < NPWM; c++)
    begin : g_pwm
        iosw_pwm_chan #(
            .PERIOD_W (PERIOD_W)
        ) u_chan (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .tick_i   (st_q.tick),
            .period_i (st_q.period[seq_interval_i]),
            .duty_i   (st_q.duty[seq_interval_i][c]),
            .pwm_o    (pwm[c])
        );
    end

    always_comb
    begin
        logic [NSRC-1:0]  src;
        logic [ACC_W-1:0] acc;
        logic             v;
        st_d = st_q;
        src  = '0;
        acc  = '0;
        v    = 1'b0;

        // pins are read only after two flops
        st_d.sync1 = {mft_rxd_i, io_rxd_i, io_in_i};
        st_d.sync2 = st_q.sync1;

        src[SRC_IO_IN0 +: 4]  = st_q.sync2[3:0];
        src[SRC_IO_RXD]       = st_q.sync2[4];
        src[SRC_MFT_RXD]      = st_q.sync2[5];
        src[SRC_TXD_UART1]    = txd_uart1_i;
        src[SRC_TXD_UART2]    = txd_uart2_i;
        src[SRC_STROBE0]      = strobe_i[0];
        src[SRC_STROBE1]      = strobe_i[1];
        src[SRC_STROBE2]      = strobe_i[2];
        src[SRC_STROBE3]      = strobe_i[3];
        src[SRC_PWM_A]        = pwm[0];
        src[SRC_PWM_B]        = pwm[1];
        src[SRC_PWM_C]        = pwm[2];
        src[SRC_PWM_D]        = pwm[3];
        src[SRC_EXPOSE]       = expose_i;
        src[SRC_READOUT]      = readout_i;
        src[SRC_SEQ_PULSEA]   = seq_pulse_a_i;
        src[SRC_SEQ_ACTIVE]   = seq_active_i;
        src[SRC_SEQ_PULSEB]   = seq_pulse_b_i;
        src[SRC_DEBOUNCE]     = debounce_out_i;
        src[SRC_PRESCALE]     = prescale_out_i;
        src[SRC_LOGIC]        = logic_result_i;
        src[SRC_TRIG_FB]      = trigger_feedback_i;

        // routing table updates; default outranks load, load outranks a write
        st_d.save = route_save_i;
        if (route_save_i)
            st_d.image = st_q.table_r;
        if (route_default_i)
        begin
            for (int d = 0; d < NDST; d++)
                st_d.table_r[d] = ROUTE_DEFAULT;
        end
        else if (route_load_i)
            st_d.table_r = nv_image_i;
        else if (route_we_i && (route_dst_i < SEL_W'(NDST)))
            st_d.table_r[route_dst_i] = route_i;

        // registered mux keeps reconfiguration glitch free on the pins
        for (int d = 0; d < NDST; d++)
        begin
            if (st_q.table_r[d].sel < SEL_W'(NSRC))
                v = src[st_q.table_r[d].sel];
            else
                v = 1'b0;
            if (st_q.table_r[d].force_hi)
                v = 1'b1;
            if (st_q.table_r[d].inv)
                v = ~v;
            st_d.dst[d] = v;
        end

        // open drain: pull low while the line is low, unpopulated ones released
        for (int i = 0; i < 4; i++)
            st_d.od_oe[i] = (i < NUM_OD) ? ~st_d.dst[DST_IO_OUT0 + i] : 1'b0;

        // 15 ns tick from a 10 ns clock by a phase accumulator; jitter one clock
        acc = ACC_W'(st_q.acc + ACC_STEP);
        st_d.tick = 1'b0;
        if (acc >= ACC_TICK)
        begin
            acc = ACC_W'(acc - ACC_TICK);
            st_d.tick = 1'b1;
        end
        st_d.acc = acc;

        if (pwm_we_i)
        begin
            st_d.period[interval_index_i] = pwm_period_ticks_i;
            st_d.duty[interval_index_i]   = pwm_duty_percent_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
            for (int d = 0; d < NDST; d++)
            begin
                st_q.table_r[d] <= ROUTE_DEFAULT;
                st_q.image[d]   <= ROUTE_DEFAULT;
            end
        end
        else
            st_q <= st_d;
    end

    assign route_table_o     = st_q.table_r;
    assign nv_image_o        = st_q.image;
    assign nv_save_o         = st_q.save;
    assign io_out_o          = 4'h0;
    assign io_out_oe_o       = st_q.od_oe;
    assign io_txd_o          = st_q.dst[DST_IO_TXD];
    assign rxd_uart1_o       = st_q.dst[DST_RXD_UART1];
    assign rxd_uart2_o       = st_q.dst[DST_RXD_UART2];
    assign acq_trigger_o     = st_q.dst[DST_ACQ_TRIG];
    assign seq_start_input_o = st_q.dst[DST_SEQ_START];
    assign debounce_in_o     = st_q.dst[DST_DEBOUNCE];
    assign prescale_in_o     = st_q.dst[DST_PRESCALE];
    assign logic_a_o         = st_q.dst[DST_LOGIC_A];
    assign logic_b_o         = st_q.dst[DST_LOGIC_B];
    assign mft_txd_o         = st_q.dst[DST_MFT_TXD];
    assign pulse_trig_o      = st_q.dst[DST_PULSE_TRIG0 +: 4];
    assign seq_pwm_a         = pwm[0];
    assign seq_pwm_b         = pwm[1];
    assign seq_pwm_c         = pwm[2];
    assign seq_pwm_d         = pwm[3];
endmodule

/* File: hdl/iosw_pkg.sv */
// shared constants and types for the io switch matrix with pwm
package iosw_pkg;
    localparam int unsigned NSRC  = 25;
    localparam int unsigned NDST  = 18;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned NPWM  = 4;
    localparam int unsigned DUTY_W = 7;

    // select code meaning no source routed
    localparam logic [SEL_W-1:0] SEL_NONE = 5'h1F;

    // source indices
    localparam int unsigned SRC_IO_IN0     = 0;
    localparam int unsigned SRC_IO_RXD     = 4;
    localparam int unsigned SRC_TXD_UART1  = 5;
    localparam int unsigned SRC_STROBE0    = 6;
    localparam int unsigned SRC_STROBE1    = 7;
    localparam int unsigned SRC_PWM_A      = 8;
    localparam int unsigned SRC_PWM_B      = 9;
    localparam int unsigned SRC_EXPOSE     = 10;
    localparam int unsigned SRC_READOUT    = 11;
    localparam int unsigned SRC_SEQ_PULSEA = 12;
    localparam int unsigned SRC_PWM_C      = 13;
    localparam int unsigned SRC_PWM_D      = 14;
    localparam int unsigned SRC_SEQ_ACTIVE = 15;
    localparam int unsigned SRC_DEBOUNCE   = 16;
    localparam int unsigned SRC_PRESCALE   = 17;
    localparam int unsigned SRC_SEQ_PULSEB = 18;
    localparam int unsigned SRC_LOGIC      = 19;
    localparam int unsigned SRC_STROBE2    = 20;
    localparam int unsigned SRC_STROBE3    = 21;
    localparam int unsigned SRC_MFT_RXD    = 22;
    localparam int unsigned SRC_TRIG_FB    = 23;
    localparam int unsigned SRC_TXD_UART2  = 24;

    // destination indices
    localparam int unsigned DST_IO_OUT0    = 0;
    localparam int unsigned DST_IO_TXD     = 4;
    localparam int unsigned DST_RXD_UART1  = 5;
    localparam int unsigned DST_ACQ_TRIG   = 6;
    localparam int unsigned DST_SEQ_START  = 7;
    localparam int unsigned DST_DEBOUNCE   = 8;
    localparam int unsigned DST_PRESCALE   = 9;
    localparam int unsigned DST_LOGIC_A    = 10;
    localparam int unsigned DST_LOGIC_B    = 11;
    localparam int unsigned DST_MFT_TXD    = 12;
    localparam int unsigned DST_PULSE_TRIG0 = 13;
    localparam int unsigned DST_RXD_UART2  = 17;

    // pwm tick timing
    localparam int unsigned CLK_PERIOD_PS = 10000;
    localparam int unsigned PWM_TICK_PS   = 15000;
    localparam int unsigned ACC_W         = 16;
    localparam logic [ACC_W-1:0] ACC_STEP = 16'(CLK_PERIOD_PS);
    localparam logic [ACC_W-1:0] ACC_TICK = 16'(PWM_TICK_PS);
    localparam logic [DUTY_W-1:0] PCT_FULL = 7'h64;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic             inv;
        logic             force_hi;
    } iosw_route_t;

    typedef iosw_route_t [NDST-1:0] iosw_table_t;
    typedef logic [NPWM-1:0][DUTY_W-1:0] iosw_duty_t;

    localparam iosw_route_t ROUTE_DEFAULT = '{sel: SEL_NONE, inv: 1'b0, force_hi: 1'b0};
endpackage

/* File: hdl/iosw_pwm_chan.sv */
// one pwm channel: tick counter over the period with duty compare
`timescale 1ns/1ps
module iosw_pwm_chan
    import iosw_pkg::*;
#(
    parameter int unsigned PERIOD_W = 16
)(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // timing
    input  wire logic                tick_i,
    input  wire logic [PERIOD_W-1:0] period_i,
    input  wire logic [DUTY_W-1:0]   duty_i,
    // output
    output logic                     pwm_o
);
    typedef struct packed {
        logic [PERIOD_W-1:0] cnt;
        logic                pwm;
    } iosw_chan_st_t;

    iosw_chan_st_t st_q;
    iosw_chan_st_t st_d;

    always_comb
    begin
        logic [DUTY_W-1:0]        duty;
        logic [PERIOD_W+DUTY_W-1:0] pos;
        logic [PERIOD_W+DUTY_W-1:0] lim;
        st_d = st_q;
        duty = (duty_i > PCT_FULL) ? PCT_FULL : duty_i;
        pos  = (PERIOD_W+DUTY_W)'(st_q.cnt) * (PERIOD_W+DUTY_W)'(PCT_FULL);
        lim  = (PERIOD_W+DUTY_W)'(period_i) * (PERIOD_W+DUTY_W)'(duty);
        if (tick_i)
        begin
            // period counted in 15 ns ticks
            if (PERIOD_W'(st_q.cnt + 1'b1) >= period_i)
                st_d.cnt = '0;
            else
                st_d.cnt = PERIOD_W'(st_q.cnt + 1'b1);
        end
        // high for duty percent of the period
        st_d.pwm = (pos < lim);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pwm_o = st_q.pwm;
endmodule

/* File: bench/iosw_checker.sv */
// concurrent checks on the io switch matrix ports
`timescale 1ns/1ps
module iosw_checker
    import iosw_pkg::*;
#(
    parameter int unsigned NUM_OD = 4
)(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // sources seen by the matrix
    input wire logic [3:0]  strobe_i,
    input wire logic        expose_i,
    input wire logic        seq_pulse_a_i,
    input wire logic        seq_pulse_b_i,
    input wire logic        seq_active_i,
    input wire logic        debounce_out_i,
    input wire logic        prescale_out_i,
    input wire logic        logic_result_i,
    input wire logic        seq_pwm_a,
    input wire logic        seq_pwm_b,
    input wire logic        seq_pwm_c,
    input wire logic        seq_pwm_d,
    // routing control
    input wire logic        route_we_i,
    input wire logic [4:0]  route_dst_i,
    input wire iosw_route_t route_i,
    input wire logic        route_default_i,
    input wire logic        route_save_i,
    input wire logic        route_load_i,
    input wire iosw_table_t nv_image_i,
    // routing state and destinations
    input wire iosw_table_t route_table_o,
    input wire iosw_table_t nv_image_o,
    input wire logic        nv_save_o,
    input wire logic [3:0]  io_out_oe_o,
    input wire logic        acq_trigger_o,
    input wire logic        seq_start_input_o,
    input wire logic        debounce_in_o,
    input wire logic        prescale_in_o,
    input wire logic        logic_a_o,
    input wire logic        logic_b_o,
    input wire logic [3:0]  pulse_trig_o
);
    // pins carry extra sync delay and uart, readout and trigger feedback sources are not ports here, so all of them are skipped
    localparam logic [31:0] SKIP = 32'h01C0083F;
    logic [31:0] src;
    logic [17:0] dst;
    logic [17:0] exp_v;
    logic [17:0] unk;
    assign src = {10'h000, strobe_i[3:2], logic_result_i, seq_pulse_b_i, prescale_out_i,
                  debounce_out_i, seq_active_i, seq_pwm_d, seq_pwm_c, seq_pulse_a_i, 1'b0,
                  expose_i, seq_pwm_b, seq_pwm_a, strobe_i[1:0], 6'h00};
    assign dst = {1'b0, pulse_trig_o, 1'b0, logic_b_o, logic_a_o, prescale_in_o,
                  debounce_in_o, seq_start_input_o, acq_trigger_o, 2'h0, ~io_out_oe_o};
    always_comb
    begin
        for (int d = 0; d < NDST; d++)
        begin
            exp_v[d] = route_table_o[d].inv ^ (route_table_o[d].force_hi
                       | src[route_table_o[d].sel]);
            unk[d]   = SKIP[route_table_o[d].sel] & ~route_table_o[d].force_hi;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // outputs still hold their reset values at the first edge after release
    property p_line(logic [17:0] m);
        !$past(rst_i) |-> (($past(exp_v) ^ dst) & ~$past(unk) & m) == 18'h00000;
    endproperty
    AST_OD_LINES: assert property (p_line(18'((1 << NUM_OD) - 1)))
        else $error("open-drain enable wrong");
    AST_ACQ_TRIG: assert property (p_line(18'h00040)) else $error("trigger wrong");
    AST_SEQ_START: assert property (p_line(18'h00080)) else $error("seq start wrong");
    AST_FILTERS: assert property (p_line(18'h00300)) else $error("filter feed wrong");
    AST_LOGIC_AB: assert property (p_line(18'h00C00)) else $error("operand wrong");
    AST_PULSE_TRIG: assert property (p_line(18'h1E000)) else $error("pulse trig wrong");
    AST_FORCE_INV: assert property (route_table_o[6].force_hi
        |=> acq_trigger_o == !$past(route_table_o[6].inv)) else $error("forced line wrong");
    AST_WRITE: assert property (route_we_i && route_dst_i < 5'h12 && !route_default_i
        && !route_load_i |=> route_table_o[$past(route_dst_i)] == $past(route_i))
        else $error("route write not taken");
    AST_REFUSE: assert property (route_we_i && route_dst_i > 5'h11 && !route_default_i
        && !route_load_i |=> $stable(route_table_o)) else $error("bad destination taken");
    AST_SAVE: assert property (route_save_i |=> nv_save_o
        && nv_image_o == $past(route_table_o)) else $error("save image wrong");
    AST_LOAD: assert property (route_load_i && !route_default_i
        |=> route_table_o == $past(nv_image_i)) else $error("load wrong");
    AST_DEFAULT: assert property (route_default_i
        |=> route_table_o == {NDST{ROUTE_DEFAULT}}) else $error("default wrong");
    cover property (route_we_i && route_dst_i > 5'h11);
    cover property (route_table_o[6].force_hi && route_table_o[6].inv);
    cover property (nv_save_o);
endmodule
bind io_switch_matrix_pwm iosw_checker #(.NUM_OD(NUM_OD)) i_chk (
    .clk_i, .rst_i, .strobe_i, .expose_i, .seq_pulse_a_i, .seq_pulse_b_i, .seq_active_i,
    .debounce_out_i, .prescale_out_i, .logic_result_i, .seq_pwm_a, .seq_pwm_b, .seq_pwm_c,
    .seq_pwm_d, .route_we_i, .route_dst_i, .route_i, .route_default_i, .route_save_i,
    .route_load_i, .nv_image_i, .route_table_o, .nv_image_o, .nv_save_o, .io_out_oe_o,
    .acq_trigger_o, .seq_start_input_o, .debounce_in_o, .prescale_in_o, .logic_a_o,
    .logic_b_o, .pulse_trig_o);

/* File: bench/iosw_partner.sv */
// on-chip function modules behind the matrix destinations
`timescale 1ns/1ps
module iosw_partner (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // from the matrix
    input  wire logic       debounce_in_i,
    input  wire logic       prescale_in_i,
    input  wire logic       logic_a_i,
    input  wire logic       logic_b_i,
    input  wire logic [3:0] pulse_trig_i,
    // back to the matrix
    output logic            debounce_out_o,
    output logic            prescale_out_o,
    output logic            logic_result_o,
    output logic [3:0]      strobe_o
);
    logic pre_q;
    // crude stand-ins: filter is one register, prescaler halves rising edges
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            {debounce_out_o, prescale_out_o, logic_result_o, strobe_o, pre_q} <= '0;
        else
        begin
            debounce_out_o <= debounce_in_i;
            pre_q          <= prescale_in_i;
            prescale_out_o <= prescale_out_o ^ (prescale_in_i & ~pre_q);
            logic_result_o <= logic_a_i & logic_b_i;
            strobe_o       <= pulse_trig_i;
        end
    end
endmodule

/* File: bench/io_switch_matrix_pwm_test.sv */
// self-checking bench for the io switch matrix with pwm
`timescale 1ns/1ps
module io_switch_matrix_pwm_test;
    import iosw_pkg::*;
    logic        clk_i, rst_i, io_rxd_i, mft_rxd_i, txd_uart1_i, txd_uart2_i, expose_i;
    logic        readout_i, seq_pulse_a_i, seq_pulse_b_i, seq_active_i, trigger_feedback_i;
    logic        debounce_out_i, prescale_out_i, logic_result_i, pwm_we_i, rnd_on;
    logic        route_we_i, route_default_i, route_save_i, route_load_i, acq_trigger_o;
    logic        seq_start_input_o, debounce_in_o, prescale_in_o, logic_a_o, logic_b_o;
    logic        seq_pwm_a, seq_pwm_b, seq_pwm_c, seq_pwm_d;
    logic [3:0]  io_in_i, strobe_i, interval_index_i, seq_interval_i, io_out_oe_o;
    logic [3:0]  pulse_trig_o;
    logic [4:0]  route_dst_i;
    logic [15:0] pwm_period_ticks_i;
    iosw_route_t route_i, rr;
    iosw_table_t nv_image_i, route_table_o, nv_image_o, tbl, saved;
    iosw_duty_t  pwm_duty_percent_i;
    int          seed = 71;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cnt [4];
    // odd periods: the 2-of-3 tick jitter cancels over 180 clocks
    localparam int PER [2] = '{5, 15};
    localparam int IVL [2] = '{3, 5};
    localparam int DTY [2][4] = '{'{50, 0, 100, 25}, '{75, 120, 1, 50}};
    localparam logic [4:0] CH_D [8] = '{5'h08, 5'h09, 5'h0D, 5'h0A, 5'h0B, 5'h00, 5'h06, 5'h07};
    localparam logic [4:0] CH_S [8] = '{5'h00, 5'h10, 5'h10, 5'h10, 5'h06, 5'h06, 5'h13, 5'h11};

    io_switch_matrix_pwm #(.NUM_OD(4), .NUM_INTERVALS(16), .PERIOD_W(16)) i_dut (
        .clk_i, .rst_i, .io_in_i, .io_rxd_i, .mft_rxd_i, .txd_uart1_i, .txd_uart2_i,
        .strobe_i, .expose_i, .readout_i, .seq_pulse_a_i, .seq_pulse_b_i, .seq_active_i,
        .debounce_out_i, .prescale_out_i, .logic_result_i, .trigger_feedback_i, .route_we_i,
        .route_dst_i, .route_i, .route_default_i, .route_save_i, .route_load_i, .nv_image_i,
        .pwm_we_i, .interval_index_i, .pwm_period_ticks_i, .pwm_duty_percent_i,
        .seq_interval_i, .route_table_o, .nv_image_o, .nv_save_o(), .io_out_o(),
        .io_out_oe_o, .io_txd_o(), .rxd_uart1_o(), .rxd_uart2_o(), .acq_trigger_o,
        .seq_start_input_o, .debounce_in_o, .prescale_in_o, .logic_a_o, .logic_b_o,
        .mft_txd_o(), .pulse_trig_o, .seq_pwm_a, .seq_pwm_b, .seq_pwm_c, .seq_pwm_d);
    iosw_partner i_far (.clk_i, .rst_i, .debounce_in_i(debounce_in_o),
        .prescale_in_i(prescale_in_o), .logic_a_i(logic_a_o), .logic_b_i(logic_b_o),
        .pulse_trig_i(pulse_trig_o), .debounce_out_o(debounce_out_i),
        .prescale_out_o(prescale_out_i), .logic_result_o(logic_result_i), .strobe_o(strobe_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        #1;
        if (rnd_on)
            {io_in_i, io_rxd_i, mft_rxd_i, txd_uart1_i, txd_uart2_i, expose_i, readout_i,
             seq_pulse_a_i, seq_pulse_b_i, seq_active_i, trigger_feedback_i} = 14'($random(seed));
    end
    task automatic chk(input logic [125:0] got, input logic [125:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        compares++;
        if (got > exp + 4 || got + 4 < exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: pwm high count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(posedge clk_i);
        #1 s = 1'b1;
        @(posedge clk_i);
        #1 s = 1'b0;
    endtask
    task automatic wr(input logic [4:0] d, input iosw_route_t r);
        route_dst_i = d;
        route_i = r;
        pulse(route_we_i);
        if (d < 5'h12)
            tbl[d] = r;
    endtask
    function automatic int hi(int p, int d);
        int n;
        n = 0;
        for (int c = 0; c < p; c++)
            if (c * 100 < p * (d > 100 ? 100 : d))
                n++;
        return n;
    endfunction
    task summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        {io_in_i, io_rxd_i, mft_rxd_i, txd_uart1_i, txd_uart2_i, expose_i, readout_i,
         seq_pulse_a_i, seq_pulse_b_i, seq_active_i, trigger_feedback_i} = '0;
        {route_we_i, route_default_i, route_save_i, route_load_i, pwm_we_i, rnd_on} = '0;
        {route_dst_i, interval_index_i, seq_interval_i, pwm_period_ticks_i} = '0;
        {nv_image_i, pwm_duty_percent_i} = '0;
        route_i = ROUTE_DEFAULT;
        tbl = {NDST{ROUTE_DEFAULT}};
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(route_table_o, tbl);
        chk({pulse_trig_o, acq_trigger_o, seq_start_input_o, debounce_in_o, logic_a_o, io_out_oe_o}, 12'h00F);
        for (int i = 0; i < 8; i++)
            wr(CH_D[i], '{CH_S[i], 1'b0, 1'b0});
        for (int v = 1; v >= 0; v--)
        begin
            io_in_i[0] = v[0];
            repeat (14) @(posedge clk_i);
            #1;
            chk({io_out_oe_o[0], pulse_trig_o[0], acq_trigger_o, seq_start_input_o}, {!v[0], v[0], v[0], 1'b1});
        end
        for (int k = 0; k < 8; k++)
        begin
            rr = '{5'h0A, k[1], k[2]};
            expose_i = k[0];
            wr(5'h06, rr);
            repeat (2) @(posedge clk_i);
            #1;
            chk(acq_trigger_o, rr.inv ^ (rr.force_hi | k[0]));
        end
        rnd_on = 1'b1;
        repeat (80)
        begin
            rr = iosw_route_t'(7'($random(seed)));
            wr(5'($random(seed)), rr);
            chk(route_table_o, tbl);
        end
        saved = tbl;
        pulse(route_save_i);
        chk(nv_image_o, saved);
        pulse(route_default_i);
        tbl = {NDST{ROUTE_DEFAULT}};
        chk(route_table_o, tbl);
        repeat (2) @(posedge clk_i);
        #1;
        chk({pulse_trig_o, acq_trigger_o, logic_a_o, io_out_oe_o}, 10'h00F);
        nv_image_i = saved;
        pulse(route_load_i);
        chk(route_table_o, saved);
        for (int k = 0; k < 2; k++)
        begin
            interval_index_i = 4'(IVL[k]);
            pwm_period_ticks_i = 16'(PER[k]);
            for (int c = 0; c < 4; c++)
                pwm_duty_percent_i[c] = 7'(DTY[k][c]);
            pulse(pwm_we_i);
        end
        for (int k = 0; k < 2; k++)
        begin
            seq_interval_i = 4'(IVL[k]);
            repeat (20) @(posedge clk_i);
            cnt = '{default: 0};
            repeat (180)
            begin
                @(posedge clk_i);
                #1;
                cnt[0] += seq_pwm_a;
                cnt[1] += seq_pwm_b;
                cnt[2] += seq_pwm_c;
                cnt[3] += seq_pwm_d;
            end
            for (int c = 0; c < 4; c++)
                near(cnt[c], 180 * hi(PER[k], DTY[k][c]) / PER[k]);
        end
        summarize();
    end
endmodule
